// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  reg         clk_i, rst_i = 1, cs = 0, we = 0, rxv = 0;
  reg  [7:0]  adr = 0, rxd = 0;
  reg  [31:0] wdat = 0, rd;
  reg  [2:0]  tog = 0;
  reg  [47:0] row [0:2];
  wire [31:0] rdat;
  wire [15:0] lp;
  wire        ack, dsr, cts, ri, dla, irq;
  integer     miscompares = 0, checks = 0, cyc_n = 0, i;
  uml_modem m (.clk_i(clk_i), .flip_i(tog), .dsr_n_o(dsr), .cts_n_o(cts), .ring_n_o(ri));
  uml_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cs), .wb_stb_i(cs),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_dat_o(rdat),
    .wb_ack_o(ack), .data_set_ready_n_i(dsr), .clear_to_send_n_i(cts),
    .ring_indicator_n_i(ri), .rx_data_i(rxd), .rx_valid_i(rxv), .lp_divisor_o(lp),
    .divisor_latch_access_o(dla), .irq_o(irq));
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  task report_and_stop;
    begin
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      cs <= 1;
      adr <= a;
      we <= w;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rd = rdat;
      cs <= 0;
      we <= 0;
      @(posedge clk_i);
    end
  endtask
  task flip(input [2:0] p);
    begin
      tog <= p;
      @(posedge clk_i);
      tog <= 0;
      @(posedge clk_i);
    end
  endtask
  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk_i) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 3000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  initial begin
    row[0] = 48'h1c_ffffff3c_3c;
    row[1] = 48'h20_12345681_81;
    row[2] = 48'h24_aaaaaa7e_7e;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (i = 0; i < 3; i = i + 1) begin
      wb(row[i][47:40], 1, row[i][39:8]);
      wb(row[i][47:40], 0, 0);
      chk(rd, {24'h0, row[i][7:0]});
    end
    chk(lp, 16'h7e81);
    wb(8'hf0, 0, 0);
    chk(rd, 0);
    for (i = 0; i < 3; i = i + 1) begin
      flip(3'h1 << i);
      wb(8'h18, 0, 0);
      chk(rd[2:0], i == 0 ? 2 : i == 1 ? 1 : 4);
      wb(8'h18, 0, 0);
      chk(rd[2:0], 0);
    end
    // masked event must stay silent, then show once unmasked
    flip(3'h4);
    wb(8'h94, 0, 0);
    chk(rd, 0);
    chk(irq, 0);
    wb(8'h94, 1, 1);
    chk(irq, 1);
    wb(8'h90, 0, 0);
    chk(rd[0], 1);
    chk(irq, 0);
    rxd <= 8'h5c;
    rxv <= 1;
    @(posedge clk_i);
    rxv <= 0;
    wb(8'h0c, 1, 32'h80);
    chk(dla, 1);
    wb(8'h4c, 0, 0);
    chk(rd, 0);
    wb(8'h0c, 1, 0);
    wb(8'h6c, 0, 0);
    chk(rd, 32'h5c);
    // second byte lands unread: overrun, both held behind the mask
    rxd <= 8'ha5;
    rxv <= 1;
    @(posedge clk_i);
    rxd <= 8'h3c;
    @(posedge clk_i);
    rxv <= 0;
    chk(irq, 0);
    wb(8'h14, 0, 0);
    chk(rd, 3);
    wb(8'h90, 0, 0);
    chk(rd, 6);
    wb(8'h31, 0, 0);
    chk(rd, 0);
    wb(8'h30, 0, 0);
    chk(rd, 32'h3c);
    wb(8'h14, 0, 0);
    chk(rd, 0);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (i = 0; i < 3; i = i + 1) begin
      wb(row[i][47:40], 0, 0);
      chk(rd, 0);
    end
    chk(lp, 0);
    // dsr and cts sit low across reset, so both report a change afterwards
    wb(8'h18, 0, 0);
    chk(rd, 32'h33);
    wb(8'h18, 0, 0);
    chk(rd, 32'h30);
    report_and_stop;
  end
endmodule // tb

// ==== uml_defs.vh ====
// Operation
// - dsr change flag, modem line status bit 1, sets when data_set_ready_n changed
// - cts change flag sets when clear_to_send_n changed since last status read
// - ring change flag sets when ring_indicator_n changed since last status read
// - 8-bit scratch byte at 0x1c, freely read/write, no side effects, upper bits zero
// - divisor low byte, read/write at 0x20, resets to zero
// - divisor high byte, read/write at 0x24, resets to zero
// - receive byte mirrored on sixteen word locations 0x30 to 0x6c
// - mirror returns data only with shadow option built and line control bit 7 zero
`ifndef UML_DEFS_VH
`define UML_DEFS_VH

// ==========================================================
// register offsets (byte addresses)
`define UML_OFS_LINE_CTRL   8'h0c
`define UML_OFS_MODEM_STAT  8'h18
`define UML_OFS_SCRATCH     8'h1c
`define UML_OFS_LPDIV_LO    8'h20
`define UML_OFS_LPDIV_HI    8'h24
`define UML_OFS_SHADOW_LO   8'h30
`define UML_OFS_SHADOW_HI   8'h6c
`define UML_OFS_LINE_STAT   8'h14
`define UML_OFS_IRQ_STAT    8'h90
`define UML_OFS_IRQ_MASK    8'h94

// ==========================================================
// field positions
`define UML_MS_DCTS         0
`define UML_MS_DSR_CHG      1
`define UML_MS_DRI          2
`define UML_MS_CTS          4
`define UML_MS_DSR          5
`define UML_MS_RI           6
`define UML_LC_DLAB         7
`define UML_LS_DREADY       0
`define UML_LS_OVERRUN      1
`define UML_IRQ_MODEM       0
`define UML_IRQ_RXDATA      1
`define UML_IRQ_OVERRUN     2
`define UML_IRQ_W           3

// ==========================================================
// reset values
`define UML_RST_BYTE        8'h00
`define UML_RST_IRQ         3'h0
`define UML_RST_PIN_N       1'b1

`endif

// ==== uml_modem.sv ====
`timescale 1ns/1ns
module uml_modem (
  input  wire       clk_i,
  input  wire [2:0] flip_i,
  output reg        dsr_n_o,
  output reg        cts_n_o,
  output reg        ring_n_o
);
  // lines rest deasserted (high) and move only when asked
  initial {dsr_n_o, cts_n_o, ring_n_o} = 3'h7;
  always @(posedge clk_i) begin
    dsr_n_o <= dsr_n_o ^ flip_i[0];
    cts_n_o <= cts_n_o ^ flip_i[1];
    ring_n_o <= ring_n_o ^ flip_i[2];
  end
endmodule // uml_modem

// ==== uml_props.sv ====
`timescale 1ns/1ns
module uml_props #(
  parameter SHADOW_EN = 1,
  parameter ADR_W     = 8
) (
  input wire             clk_i,
  input wire             rst_i,
  input wire             ce_i,
  input wire             wb_cyc_i,
  input wire             wb_stb_i,
  input wire             wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [31:0]      wb_dat_i,
  input wire [3:0]       wb_sel_i,
  input wire [31:0]      wb_dat_o,
  input wire             wb_ack_o,
  input wire             data_set_ready_n_i,
  input wire             clear_to_send_n_i,
  input wire             ring_indicator_n_i,
  input wire [7:0]       rx_data_i,
  input wire             rx_valid_i,
  input wire [15:0]      lp_divisor_o,
  input wire             divisor_latch_access_o,
  input wire             irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  wire       tk    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       rd    = tk & ~wb_we_i;
  wire       wr    = tk & wb_we_i & wb_sel_i[0];
  wire       rd_ms = rd & (wb_adr_i == 8'h18);
  wire       rd_sh = rd & (wb_adr_i >= 8'h30) & (wb_adr_i <= 8'h6c) & (wb_adr_i[1:0] == 2'h0);
  wire [2:0] pins  = {data_set_ready_n_i, clear_to_send_n_i, ring_indicator_n_i};
  reg  [7:0] scratch_ff;
  reg  [7:0] rxb_ff;
  reg        rdy_ff;
  // ===================================================
  // expected scratch and receive contents, frozen with the clock enable
  always @(posedge clk_i) begin
    if (rst_i) begin
      scratch_ff <= 8'h00;
      rdy_ff     <= 1'b0;
    end else if (ce_i) begin
      if (wr && wb_adr_i == 8'h1c)
        scratch_ff <= wb_dat_i[7:0];
      if (rx_valid_i)
        rxb_ff <= rx_data_i;
      rdy_ff <= rx_valid_i | (rdy_ff & ~(rd_sh & ~divisor_latch_access_o));
    end
  end
  // ===================================================
  // properties
  property p_dsr_chg; $changed(data_set_ready_n_i) ##1 rd_ms |=> wb_dat_o[1]; endproperty
  property p_cts_chg; $changed(clear_to_send_n_i) ##1 rd_ms |=> wb_dat_o[0]; endproperty
  property p_ri_chg; $changed(ring_indicator_n_i) ##1 rd_ms |=> wb_dat_o[2]; endproperty
  // flags must be gone when nothing moved since the previous status read
  property p_clr;
    (rd_ms && $stable(pins)) ##1 ($stable(pins)[*3] ##0 rd_ms) |=> wb_dat_o[2:0] == 3'h0;
  endproperty
  property p_scratch; rd && wb_adr_i == 8'h1c |=> wb_dat_o == {24'h0, scratch_ff}; endproperty
  property p_lo; wr && wb_adr_i == 8'h20 |=> lp_divisor_o[7:0] == $past(wb_dat_i[7:0]); endproperty
  property p_hi; wr && wb_adr_i == 8'h24 |=> lp_divisor_o[15:8] == $past(wb_dat_i[7:0]); endproperty
  property p_sh;
    rd_sh && rdy_ff && !divisor_latch_access_o && SHADOW_EN != 0 |=>
      wb_dat_o == {24'h0, $past(rxb_ff)};
  endproperty
  property p_dla; rd_sh && divisor_latch_access_o |=> wb_dat_o == 32'h0; endproperty
  a_dsr_chg: assert property (p_dsr_chg) else $error("dsr change flag missing");
  a_cts_chg: assert property (p_cts_chg) else $error("cts change flag missing");
  a_ri_chg: assert property (p_ri_chg) else $error("ring change flag missing");
  a_clr: assert property (p_clr) else $error("change flags not cleared");
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");
  a_lo: assert property (p_lo) else $error("divisor low byte wrong");
  a_hi: assert property (p_hi) else $error("divisor high byte wrong");
  a_sh: assert property (p_sh) else $error("shadow read wrong");
  a_dla: assert property (p_dla) else $error("shadow read with latch access");
  c_ms: cover property (rd_ms);
  c_sh: cover property (rd_sh && !divisor_latch_access_o);
  c_dla: cover property (rd_sh && divisor_latch_access_o);
  c_irq: cover property (irq_o);
endmodule // uml_props

bind uml_regs uml_props #(.SHADOW_EN(SHADOW_EN), .ADR_W(ADR_W)) u_props (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
  .wb_dat_o, .wb_ack_o, .data_set_ready_n_i, .clear_to_send_n_i, .ring_indicator_n_i,
  .rx_data_i, .rx_valid_i, .lp_divisor_o, .divisor_latch_access_o, .irq_o);

// ==== uml_regs.v ====
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ns
`include "uml_defs.vh"

module uml_regs #(
  parameter       SHADOW_EN = 1,
  parameter       ADR_W     = 8
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              ce_i,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [ADR_W-1:0]  wb_adr_i,
  input  wire [31:0]       wb_dat_i,
  input  wire [3:0]        wb_sel_i,
  output wire [31:0]       wb_dat_o,
  output wire              wb_ack_o,
  input  wire              data_set_ready_n_i,
  input  wire              clear_to_send_n_i,
  input  wire              ring_indicator_n_i,
  input  wire [7:0]        rx_data_i,
  input  wire              rx_valid_i,
  output wire [15:0]       lp_divisor_o,
  output wire              divisor_latch_access_o,
  output wire              irq_o
);

  // ========================================================
  // bus decode
  wire        req     = wb_cyc_i & wb_stb_i;
  reg         ack_ff;
  wire        take    = req & ~ack_ff;
  wire        wr      = take & wb_we_i & wb_sel_i[0];
  wire        rd      = take & ~wb_we_i;
  wire        sel_lc  = (wb_adr_i == `UML_OFS_LINE_CTRL);
  wire        sel_ms  = (wb_adr_i == `UML_OFS_MODEM_STAT);
  wire        sel_ls  = (wb_adr_i == `UML_OFS_LINE_STAT);
  wire        sel_sc  = (wb_adr_i == `UML_OFS_SCRATCH);
  wire        sel_dl  = (wb_adr_i == `UML_OFS_LPDIV_LO);
  wire        sel_dh  = (wb_adr_i == `UML_OFS_LPDIV_HI);
  wire        sel_is  = (wb_adr_i == `UML_OFS_IRQ_STAT);
  wire        sel_im  = (wb_adr_i == `UML_OFS_IRQ_MASK);
  // sixteen word slots; low two address bits must be zero
  wire        sel_sh  = (wb_adr_i >= `UML_OFS_SHADOW_LO) &&
                        (wb_adr_i <= `UML_OFS_SHADOW_HI) &&
                        (wb_adr_i[1:0] == 2'b00);

  // ========================================================
  // storage
  reg  [7:0]  line_ctrl_ff;
  reg  [7:0]  scratch_ff;
  reg  [7:0]  lpdiv_lo_ff;
  reg  [7:0]  lpdiv_hi_ff;
  reg  [7:0]  rx_buf_ff;
  reg  [2:0]  irq_mask_ff;
  wire        rx_ready;
  wire        overrun;
  wire        ch_dsr;
  wire        ch_cts;
  wire        ch_ri;
  wire        d_dsr;
  wire        d_cts;
  wire        d_ri;
  wire [2:0]  irq_stat;
  reg  [31:0] dat_ff;

  // shadow reads only valid with the option built and the latch bit low
  wire        shadow_ok = (SHADOW_EN != 0) &&
                          ~line_ctrl_ff[`UML_LC_DLAB];
  wire        rd_shadow = rd & sel_sh & shadow_ok;
  wire        rd_modem  = rd & sel_ms;
  wire        rd_line   = rd & sel_ls;
  wire        rd_irq    = rd & sel_is;

  // ========================================================
  // modem change detection
  // a change in the very cycle of the clearing read still lands
  uml_pin_change u_dsr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_n_i (data_set_ready_n_i),
    .clr_i   (rd_modem),
    .chg_o   (ch_dsr),
    .flag_o  (d_dsr)
  );

  uml_pin_change u_cts (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_n_i (clear_to_send_n_i),
    .clr_i   (rd_modem),
    .chg_o   (ch_cts),
    .flag_o  (d_cts)
  );

  uml_pin_change u_ri (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_n_i (ring_indicator_n_i),
    .clr_i   (rd_modem),
    .chg_o   (ch_ri),
    .flag_o  (d_ri)
  );

  // ========================================================
  // receive holding byte
  // overrun: new byte lands while the old one is unread
  wire        ovr_evt = rx_valid_i & rx_ready & ~rd_shadow;

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf_ff <= `UML_RST_BYTE;
    end else if (ce_i) begin
      if (rx_valid_i) begin
        rx_buf_ff <= rx_data_i;
      end
    end
  end

  // ready is consumed only by a shadow read that really returned the byte
  uml_sticky #(
    .W (1)
  ) u_ready (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .set_i  (rx_valid_i),
    .clr_i  (rd_shadow),
    .flag_o (rx_ready)
  );

  uml_sticky #(
    .W (1)
  ) u_overrun (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .set_i  (ovr_evt),
    .clr_i  (rd_line),
    .flag_o (overrun)
  );

  // ========================================================
  // software registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      line_ctrl_ff <= `UML_RST_BYTE;
      scratch_ff   <= `UML_RST_BYTE;
      lpdiv_lo_ff  <= `UML_RST_BYTE;
      lpdiv_hi_ff  <= `UML_RST_BYTE;
      irq_mask_ff  <= `UML_RST_IRQ;
    end else if (ce_i && wr) begin
      if (sel_lc) begin
        line_ctrl_ff <= wb_dat_i[7:0];
      end
      if (sel_sc) begin
        scratch_ff <= wb_dat_i[7:0];
      end
      if (sel_dl) begin
        lpdiv_lo_ff <= wb_dat_i[7:0];
      end
      if (sel_dh) begin
        lpdiv_hi_ff <= wb_dat_i[7:0];
      end
      if (sel_im) begin
        irq_mask_ff <= wb_dat_i[`UML_IRQ_W-1:0];
      end
    end
  end

  // ========================================================
  // interrupt status: sticky, cleared by reading, set wins
  wire [2:0]  irq_evt;
  assign irq_evt[`UML_IRQ_MODEM]   = ch_dsr | ch_cts | ch_ri;
  assign irq_evt[`UML_IRQ_RXDATA]  = rx_valid_i;
  assign irq_evt[`UML_IRQ_OVERRUN] = ovr_evt;

  uml_sticky #(
    .W (`UML_IRQ_W)
  ) u_irq_stat (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .set_i  (irq_evt),
    .clr_i  (rd_irq),
    .flag_o (irq_stat)
  );

  // ========================================================
  // read mux: values before any read side effect
  reg  [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    if (sel_lc) begin
      rd_val[7:0] = line_ctrl_ff;
    end
    if (sel_ms) begin
      rd_val[`UML_MS_DCTS]    = d_cts;
      rd_val[`UML_MS_DSR_CHG] = d_dsr;
      rd_val[`UML_MS_DRI]     = d_ri;
      rd_val[`UML_MS_CTS]  = ~clear_to_send_n_i;
      rd_val[`UML_MS_DSR]  = ~data_set_ready_n_i;
      rd_val[`UML_MS_RI]   = ~ring_indicator_n_i;
    end
    if (sel_ls) begin
      rd_val[`UML_LS_DREADY]  = rx_ready;
      rd_val[`UML_LS_OVERRUN] = overrun;
    end
    if (sel_sc) begin
      rd_val[7:0] = scratch_ff;
    end
    if (sel_dl) begin
      rd_val[7:0] = lpdiv_lo_ff;
    end
    if (sel_dh) begin
      rd_val[7:0] = lpdiv_hi_ff;
    end
    if (sel_sh && shadow_ok) begin
      rd_val[7:0] = rx_buf_ff;
    end
    if (sel_is) begin
      rd_val[`UML_IRQ_W-1:0] = irq_stat;
    end
    if (sel_im) begin
      rd_val[`UML_IRQ_W-1:0] = irq_mask_ff;
    end
  end

  // ========================================================
  // one-wait-state answer; unmapped reads return zero, writes dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= take;
      if (rd) begin
        dat_ff <= rd_val;
      end
    end
  end

  assign wb_ack_o               = ack_ff;
  assign wb_dat_o               = dat_ff;
  assign lp_divisor_o           = {lpdiv_hi_ff, lpdiv_lo_ff};
  assign divisor_latch_access_o = line_ctrl_ff[`UML_LC_DLAB];
  assign irq_o                  = |(irq_stat & irq_mask_ff);

endmodule // uml_regs

// ==========================================================
// sticky flags: an event in the cycle of the clearing read wins
module uml_sticky #(
  parameter W = 1
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          ce_i,
  input  wire [W-1:0]  set_i,
  input  wire          clr_i,
  output wire [W-1:0]  flag_o
);

  reg  [W-1:0] flag_ff;
  wire [W-1:0] nxt_flag = set_i | (flag_ff & {W{~clr_i}});

  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= {W{1'b0}};
    end else if (ce_i) begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;

endmodule // uml_sticky

// ==========================================================
// one modem line: change against the last sample, held until read
module uml_pin_change (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire pin_n_i,
  input  wire clr_i,
  output wire chg_o,
  output wire flag_o
);

  // last sample resets to the idle level, so a line already low shows a change
  reg         prev_ff;
  wire        chg = pin_n_i ^ prev_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= `UML_RST_PIN_N;
    end else if (ce_i) begin
      prev_ff <= pin_n_i;
    end
  end

  uml_sticky #(
    .W (1)
  ) u_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .set_i  (chg),
    .clr_i  (clr_i),
    .flag_o (flag_o)
  );

  assign chg_o = chg;

endmodule // uml_pin_change
